/* File: hdl/twst_top.sv */
// Two-wire slave transmitter with bus-error handling and a Wishbone register port.
//
// Local design decisions: the Wishbone register port and the register offsets.
`default_nettype none

module twst_top
#(
  parameter int ADR_W = 8
)
(
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_ce,
  input  wire logic             i_wb_cyc,
  input  wire logic             i_wb_stb,
  input  wire logic             i_wb_we,
  input  wire logic [ADR_W-1:0] i_wb_adr,
  input  wire logic [3:0]       i_wb_sel,
  input  wire logic [31:0]      i_wb_dat,
  output logic                  o_wb_ack,
  output logic [31:0]           o_wb_dat,
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  output logic                  o_scl_oe_n,
  output logic                  o_sda_oe_n,
  output logic                  o_scl_out,
  output logic                  o_sda_out,
  input  wire logic             i_arb_lost,
  output logic                  o_enter_slave_rx,
  output logic                  o_send_start
);
  import twst_pkg::*;

  // The decoder reads eight address bits, so a narrower bus cannot be served.
  if (ADR_W < 8)
  begin : g_adr_w_check
    $error("ADR_W must be at least eight");
  end

  typedef enum logic [6:0] {
    S_IDLE     = 7'h01,
    S_ADDR     = 7'h02,
    S_ADDR_ACK = 7'h04,
    S_TX_WAIT  = 7'h08,
    S_TX_BIT   = 7'h10,
    S_TX_ACK   = 7'h20,
    S_ERROR    = 7'h40
  } twst_state_type;

  twst_line_type  line;
  twst_state_type state_ff, nxt_state;
  logic [7:0]     own_ff, nxt_own;
  logic [7:0]     data_ff, nxt_data;
  logic [7:0]     shift_ff, nxt_shift;
  logic [7:0]     status_ff, nxt_status;
  logic [3:0]     bit_ff, nxt_bit;
  logic           en_ff, nxt_en;
  logic           ack_en_ff, nxt_ack_en;
  logic           beg_ff, nxt_beg;
  logic           end_ff, nxt_end;
  logic           flag_ff, nxt_flag;
  logic           last_ff, nxt_last;
  logic           sda_low_ff, nxt_sda_low;
  logic           lost_ff, nxt_lost;
  logic           busy_ff, nxt_busy;
  logic           pend_ff, nxt_pend;
  logic           start_ff, nxt_start;
  logic           rx_ff, nxt_rx;
  logic           ack_ff, nxt_ack;
  logic [31:0]    rdat_ff, nxt_rdat;
  logic           wb_req, wb_take, ctl_wr, ctl_clear;
  logic           hw_set, addr_done, own_hit, gc_hit, illegal, bus_err;
  logic [7:0]     status_view, wbyte;

  twst_line_sampler u_sampler
  (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .i_scl    (i_scl),
    .i_sda    (i_sda),
    .o_line   (line)
  );

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Writes take effect on the edge where the master samples ack high.
  assign wb_req      = i_wb_cyc && i_wb_stb;
  assign wb_take     = wb_req && ack_ff;
  assign wbyte       = i_wb_dat[7:0];
  assign ctl_wr      = wb_take && i_wb_we && i_wb_sel[0]
                       && (i_wb_adr[7:0] == OFS_BUS_CONTROL);
  assign ctl_clear   = ctl_wr && wbyte[BIT_EVENT_FLAG];
  assign status_view = flag_ff ? status_ff : ST_NO_INFO;

  always_comb
  begin
    nxt_ack  = ack_ff;
    nxt_rdat = rdat_ff;
    if (i_ce)
    begin
      nxt_ack  = wb_req && !ack_ff;
      nxt_rdat = 32'h0000_0000;
      case (i_wb_adr[7:0])
        OFS_OWN_ADDRESS: nxt_rdat[7:0] = own_ff;
        OFS_BUS_CONTROL: nxt_rdat[7:0] = {flag_ff, ack_en_ff, beg_ff, end_ff,
                                          1'b0, en_ff, 2'b00};
        OFS_BUS_STATUS:  nxt_rdat[7:0] = status_view;
        OFS_SHIFT_DATA:  nxt_rdat[7:0] = data_ff;
        default:         nxt_rdat      = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address match
  // ----------------------------------------------------------------
  assign addr_done = (state_ff == S_ADDR) && line.scl_fall && (bit_ff == BITS_PER_BYTE);
  assign own_hit   = (shift_ff[7:1] == own_ff[7:1]) && ack_en_ff;
  assign gc_hit    = (shift_ff[7:1] == BROADCAST_ADDRESS[7:1]) && own_ff[BIT_BROADCAST]
                     && ack_en_ff && !shift_ff[0];
  assign illegal   = ((state_ff == S_ADDR) && (bit_ff != 4'h0))
                     || (state_ff == S_ADDR_ACK) || (state_ff == S_TX_BIT)
                     || (state_ff == S_TX_ACK);
  assign bus_err   = en_ff && (line.start || line.stop) && illegal;

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_own     = own_ff;
    nxt_data    = data_ff;
    nxt_shift   = shift_ff;
    nxt_status  = status_ff;
    nxt_bit     = bit_ff;
    nxt_en      = en_ff;
    nxt_ack_en  = ack_en_ff;
    nxt_beg     = beg_ff;
    nxt_end     = end_ff;
    nxt_last    = last_ff;
    nxt_sda_low = sda_low_ff;
    nxt_lost    = lost_ff;
    nxt_busy    = busy_ff;
    nxt_pend    = pend_ff;
    nxt_start   = 1'b0;
    nxt_rx      = 1'b0;
    hw_set      = 1'b0;
    nxt_flag    = flag_ff;
    if (i_ce)
    begin
      if (wb_take && i_wb_we && i_wb_sel[0] && (i_wb_adr[7:0] == OFS_OWN_ADDRESS))
        nxt_own = wbyte;
      if (wb_take && i_wb_we && i_wb_sel[0] && (i_wb_adr[7:0] == OFS_SHIFT_DATA))
        nxt_data = wbyte;
      if (ctl_wr)
      begin
        nxt_en     = wbyte[BIT_IF_ENABLE];
        nxt_ack_en = wbyte[BIT_ACK_ENABLE];
        nxt_beg    = wbyte[BIT_BEGIN_REQ];
        nxt_end    = wbyte[BIT_END_REQ];
      end
      if (line.start)
        nxt_busy = 1'b1;
      if (line.stop)
        nxt_busy = 1'b0;
      // A queued START waits for the bus to go free; the master side takes the pulse.
      if (pend_ff && !busy_ff)
      begin
        nxt_start = 1'b1;
        nxt_pend  = 1'b0;
      end
      case (state_ff)
        S_IDLE: ;
        S_ADDR:
        begin
          if (line.scl_rise)
          begin
            nxt_shift = {shift_ff[6:0], line.sda};
            nxt_bit   = bit_ff + 4'h1;
          end
          if (addr_done)
          begin
            nxt_state = S_IDLE;
            if (own_hit && shift_ff[0])
            begin
              nxt_state   = S_ADDR_ACK;
              nxt_sda_low = 1'b1;
            end
            else if (own_hit || gc_hit)
              nxt_rx = 1'b1;
          end
        end
        S_ADDR_ACK:
        begin
          if (line.scl_fall)
          begin
            nxt_sda_low = 1'b0;
            hw_set      = 1'b1;
            nxt_status  = lost_ff ? ST_LOST_READ : ST_OWN_READ;
            nxt_lost    = 1'b0;
            nxt_state   = S_TX_WAIT;
          end
        end
        S_TX_WAIT:
        begin
          if (ctl_clear)
          begin
            nxt_shift   = data_ff;
            nxt_sda_low = !data_ff[7];
            nxt_last    = !wbyte[BIT_ACK_ENABLE];
            nxt_bit     = 4'h0;
            nxt_state   = S_TX_BIT;
          end
        end
        S_TX_BIT:
        begin
          if (line.scl_fall)
          begin
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == BITS_PER_BYTE - 4'h1)
            begin
              nxt_sda_low = 1'b0;
              nxt_state   = S_TX_ACK;
            end
            else
            begin
              nxt_shift   = {shift_ff[6:0], 1'b1};
              nxt_sda_low = !shift_ff[6];
            end
          end
        end
        S_TX_ACK:
        begin
          if (line.scl_rise)
            nxt_shift[0] = line.sda;
          if (line.scl_fall)
          begin
            hw_set    = 1'b1;
            nxt_state = S_IDLE;
            if (shift_ff[0])
              nxt_status = ST_DATA_NACK;
            else if (last_ff)
              nxt_status = ST_LAST_ACK;
            else
            begin
              nxt_status = ST_DATA_ACK;
              nxt_state  = S_TX_WAIT;
            end
          end
        end
        S_ERROR:
        begin
          if (ctl_clear && wbyte[BIT_END_REQ])
          begin
            nxt_state = S_IDLE;
            nxt_end   = 1'b0;
          end
        end
        default: nxt_state = S_IDLE;
      endcase
      // Recognition after C0h/C8h follows the ack enable bit written with the clear.
      if (ctl_clear && flag_ff && wbyte[BIT_BEGIN_REQ]
          && ((status_ff == ST_DATA_NACK) || (status_ff == ST_LAST_ACK)))
        nxt_pend = 1'b1;
      if (bus_err)
      begin
        hw_set      = 1'b1;
        nxt_status  = ST_BUS_ERROR;
        nxt_state   = S_ERROR;
        nxt_sda_low = 1'b0;
      end
      else if (en_ff && line.start && (state_ff != S_ERROR))
      begin
        nxt_state   = S_ADDR;
        nxt_bit     = 4'h0;
        nxt_sda_low = 1'b0;
      end
      else if (en_ff && line.stop && (state_ff != S_ERROR))
      begin
        nxt_state   = S_IDLE;
        nxt_sda_low = 1'b0;
        nxt_lost    = 1'b0;
      end
      // A loss reported in the cycle that consumes the old one must not be dropped.
      if (i_arb_lost)
        nxt_lost = 1'b1;
      // A hardware event in the same cycle as a software clear keeps the flag set.
      if (hw_set)
        nxt_flag = 1'b1;
      else if (ctl_clear)
        nxt_flag = 1'b0;
      if (!en_ff)
      begin
        nxt_state   = S_IDLE;
        nxt_sda_low = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_ff   <= S_IDLE;
      own_ff     <= RST_OWN_ADDRESS;
      data_ff    <= RST_SHIFT_DATA;
      shift_ff   <= RST_SHIFT_DATA;
      status_ff  <= ST_NO_INFO;
      bit_ff     <= 4'h0;
      en_ff      <= 1'b0;
      ack_en_ff  <= 1'b0;
      beg_ff     <= 1'b0;
      end_ff     <= 1'b0;
      flag_ff    <= 1'b0;
      last_ff    <= 1'b0;
      sda_low_ff <= 1'b0;
      lost_ff    <= 1'b0;
      busy_ff    <= 1'b0;
      pend_ff    <= 1'b0;
      start_ff   <= 1'b0;
      rx_ff      <= 1'b0;
      ack_ff     <= 1'b0;
      rdat_ff    <= 32'h0000_0000;
    end
    else
    begin
      state_ff   <= nxt_state;
      own_ff     <= nxt_own;
      data_ff    <= nxt_data;
      shift_ff   <= nxt_shift;
      status_ff  <= nxt_status;
      bit_ff     <= nxt_bit;
      en_ff      <= nxt_en;
      ack_en_ff  <= nxt_ack_en;
      beg_ff     <= nxt_beg;
      end_ff     <= nxt_end;
      flag_ff    <= nxt_flag;
      last_ff    <= nxt_last;
      sda_low_ff <= nxt_sda_low;
      lost_ff    <= nxt_lost;
      busy_ff    <= nxt_busy;
      pend_ff    <= nxt_pend;
      start_ff   <= nxt_start;
      rx_ff      <= nxt_rx;
      ack_ff     <= nxt_ack;
      rdat_ff    <= nxt_rdat;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The clock line is held low only while software owes the next byte.
  assign o_scl_oe_n       = !(flag_ff && (state_ff == S_TX_WAIT));
  assign o_sda_oe_n       = !sda_low_ff;
  assign o_scl_out        = 1'b0;
  assign o_sda_out        = 1'b0;
  assign o_wb_ack         = ack_ff;
  assign o_wb_dat         = rdat_ff;
  assign o_enter_slave_rx = rx_ff;
  assign o_send_start     = start_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence err_clear_s;
    i_ce && (state_ff == S_ERROR) && ctl_clear && wbyte[BIT_END_REQ];
  endsequence
  sequence released_s;
    (state_ff == S_IDLE) && !end_ff && o_sda_oe_n && o_scl_oe_n;
  endsequence

  status_no_info_a: assert property (ack_ff && $past(i_ce) && !$past(flag_ff)
    && ($past(i_wb_adr[7:0]) == OFS_BUS_STATUS) |-> o_wb_dat[7:0] == ST_NO_INFO)
    else $error("status not F8h with flag clear");
  own_match_a: assert property (i_ce && addr_done && (shift_ff[7:1] != own_ff[7:1])
    |=> state_ff != S_ADDR_ACK)
    else $error("foreign address acknowledged");
  gc_ignore_a: assert property (i_ce && addr_done && (shift_ff[7:1] == 7'h00)
    && !own_ff[BIT_BROADCAST] && (own_ff[7:1] != 7'h00) |=> !o_enter_slave_rx)
    else $error("general call answered while disabled");
  read_code_a: assert property (i_ce && !bus_err && (state_ff == S_ADDR_ACK) && line.scl_fall
    && !lost_ff |=> flag_ff && (status_ff == ST_OWN_READ))
    else $error("own read address did not post A8h");
  lost_code_a: assert property (i_ce && !bus_err && (state_ff == S_ADDR_ACK) && line.scl_fall
    && lost_ff |=> flag_ff && (status_ff == ST_LOST_READ))
    else $error("lost arbitration read did not post B0h");
  nack_code_a: assert property (i_ce && !bus_err && (state_ff == S_TX_ACK) && line.scl_fall
    && shift_ff[0] |=> (status_ff == ST_DATA_NACK) && (state_ff == S_IDLE))
    else $error("master NACK did not post C0h");
  last_byte_a: assert property (i_ce && (state_ff == S_TX_WAIT) && ctl_clear
    && !bus_err && !wbyte[BIT_ACK_ENABLE] |=> last_ff && (state_ff == S_TX_BIT))
    else $error("last byte not marked");
  idle_free_a: assert property ((state_ff == S_IDLE) |-> o_sda_oe_n)
    else $error("data line driven while not addressed");
  no_ack_a: assert property (i_ce && addr_done && !ack_en_ff |=> state_ff != S_ADDR_ACK)
    else $error("address acknowledged with ack enable low");
  err_code_a: assert property (i_ce && bus_err |=> flag_ff && (status_ff == ST_BUS_ERROR)
    && o_sda_oe_n)
    else $error("bus error not posted as 00h");
  recover_a: assert property (err_clear_s |=> released_s)
    else $error("bus error recovery incomplete");

endmodule // twst_top

`default_nettype wire

/* File: hdl/twst_pkg.sv */
// Package with constants and types of the two-wire slave transmitter block.
`default_nettype none

package twst_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OWN_ADDRESS = 8'h00;
  localparam logic [7:0] OFS_BUS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BUS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_SHIFT_DATA  = 8'h0c;

  // ----------------------------------------------------------------
  // Control field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_EVENT_FLAG  = 7;
  localparam int BIT_ACK_ENABLE  = 6;
  localparam int BIT_BEGIN_REQ   = 5;
  localparam int BIT_END_REQ     = 4;
  localparam int BIT_IF_ENABLE   = 2;
  localparam int BIT_BROADCAST   = 0;
  localparam logic [7:0] RST_OWN_ADDRESS = 8'h00;
  localparam logic [7:0] RST_SHIFT_DATA  = 8'hff;
  localparam logic [7:0] BROADCAST_ADDRESS = 8'h00;

  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_OWN_READ   = 8'ha8;
  localparam logic [7:0] ST_LOST_READ  = 8'hb0;
  localparam logic [7:0] ST_DATA_ACK   = 8'hb8;
  localparam logic [7:0] ST_DATA_NACK  = 8'hc0;
  localparam logic [7:0] ST_LAST_ACK   = 8'hc8;
  localparam logic [7:0] ST_NO_INFO    = 8'hf8;
  localparam logic [7:0] ST_BUS_ERROR  = 8'h00;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Synchronised bus line levels and the events found on them.
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } twst_line_type;

endpackage : twst_pkg

`default_nettype wire

/* File: hdl/twst_line_sampler.sv */
// Synchroniser and edge, START and STOP finder for the two bus lines.
`default_nettype none

module twst_line_sampler
(
  input  wire logic                    i_clk,
  input  wire logic                    i_arst_n,
  input  wire logic                    i_ce,
  input  wire logic                    i_scl,
  input  wire logic                    i_sda,
  output var  twst_pkg::twst_line_type o_line
);
  import twst_pkg::*;

  logic [1:0] meta_ff;
  logic [1:0] sync_ff;
  logic [1:0] prev_ff;
  logic [1:0] nxt_meta;
  logic [1:0] nxt_sync;
  logic [1:0] nxt_prev;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, then a delayed copy for edge finding
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    nxt_prev = prev_ff;
    if (i_ce)
    begin
      nxt_meta = {i_scl, i_sda};
      nxt_sync = meta_ff;
      nxt_prev = sync_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
      prev_ff <= 2'h3;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  // Conditions are only taken while the clock line stays high on both samples.
  always_comb
  begin
    o_line.scl      = sync_ff[1];
    o_line.sda      = sync_ff[0];
    o_line.scl_rise = sync_ff[1] && !prev_ff[1];
    o_line.scl_fall = !sync_ff[1] && prev_ff[1];
    o_line.start    = sync_ff[1] && prev_ff[1] && !sync_ff[0] && prev_ff[0];
    o_line.stop     = sync_ff[1] && prev_ff[1] && sync_ff[0] && !prev_ff[0];
  end

endmodule // twst_line_sampler

`default_nettype wire

/* File: verification/twst_bus_master.sv */
// Behavioural two-wire bus master receiver used as the far side of the block.
`default_nettype none

module twst_bus_master
(
  input  wire logic i_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // A one releases a line, so the pull-up shows through.
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic hc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic start_c();
    o_sda <= 1'b1;
    hc(2);
    o_scl <= 1'b1;
    hc(4);
    o_sda <= 1'b0;
    hc(4);
    o_scl <= 1'b0;
  endtask

  task automatic stop_c();
    hc(2);
    o_sda <= 1'b0;
    hc(2);
    o_scl <= 1'b1;
    hc(4);
    o_sda <= 1'b1;
    hc(4);
  endtask

  // The wait for a high clock honours stretching by the slave.
  task automatic bit_x(input logic b, output logic r);
    int n;
    n = 0;
    hc(2);
    o_sda <= b;
    hc(2);
    o_scl <= 1'b1;
    do @(negedge i_clk); while (i_scl !== 1'b1 && ++n < 4000);
    hc(3);
    @(negedge i_clk);
    r = i_sda;
    hc(1);
    o_scl <= 1'b0;
  endtask

  task automatic byte_x(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                        output logic ak_seen);
    for (int i = 7; i >= 0; i--)
      bit_x(tx[i], rx[i]);
    bit_x(ak, ak_seen);
  endtask
endmodule // twst_bus_master

`default_nettype wire

/* File: verification/twst_tb_top.sv */
// Self-checking testbench of the two-wire slave transmitter.
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module twst_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import twst_pkg::*;

  logic        i_clk, i_arst_n, cyc, stb, we, arb, ack, scl_oe_n, sda_oe_n;
  logic        m_scl, m_sda, scl_w, sda_w, rx_p, st_p, scl_o, sda_o;
  logic [7:0]  adr;
  logic [31:0] dat, rdat;
  logic [7:0]  q;
  logic        a;
  int          failures, n_checks, n_rx, n_start, n_cyc;

  // Open-drain wires with pull-ups: any party pulling low wins.
  assign scl_w = m_scl & scl_oe_n;
  assign sda_w = m_sda & sda_oe_n;

  twst_top i_twst_top (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_scl(scl_w), .i_sda(sda_w), .o_scl_oe_n(scl_oe_n),
    .o_sda_oe_n(sda_oe_n), .o_scl_out(scl_o), .o_sda_out(sda_o), .i_arb_lost(arb),
    .o_enter_slave_rx(rx_p), .o_send_start(st_p));

  twst_bus_master i_twst_bus_master (.i_clk(i_clk), .i_scl(scl_w), .i_sda(sda_w),
    .o_scl(m_scl), .o_sda(m_sda));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // Pulse counters and the cut-off for a hang.
  always @(posedge i_clk)
  begin
    n_rx    <= n_rx + int'(rx_p === 1'b1);
    n_start <= n_start + int'(st_p === 1'b1);
    n_cyc   <= n_cyc + 1;
    if (n_cyc == 40000)
    begin
      failures++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wb_go(input logic [7:0] ad, input logic w, input logic [7:0] d,
                       output logic [7:0] r);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= ad;
    dat <= {24'h0, d};
    do @(posedge i_clk); while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic [7:0] r;
    wb_go(ad, 1'b1, d, r);
  endtask

  task automatic chk_sts(input logic [7:0] e);
    logic [7:0] r;
    wb_go(OFS_BUS_STATUS, 1'b0, 8'h00, r);
    `CHK("status", e, r)
  endtask

  task automatic wait_flag();
    logic [7:0] r;
    int         n;
    n = 0;
    do wb_go(OFS_BUS_CONTROL, 1'b0, 8'h00, r); while (r[7] !== 1'b1 && ++n < 100);
  endtask

  task automatic t_reset();
    chk_sts(ST_NO_INFO);
    wb_go(OFS_BUS_CONTROL, 1'b0, 8'h00, q);
    `CHK("control", 8'h00, q)
    `CHK("lines", 2'b11, {scl_oe_n, sda_oe_n})
    `CHK("pin value", 2'b00, {scl_o, sda_o})
  endtask

  task automatic t_read_ack();
    wr(OFS_OWN_ADDRESS, 8'h53);
    wr(OFS_BUS_CONTROL, 8'h44);
    i_twst_bus_master.start_c();
    i_twst_bus_master.byte_x(8'h53, 1'b1, q, a);
    `CHK("addr ack", 1'b0, a)
    wait_flag();
    chk_sts(ST_OWN_READ);
    `CHK("stretch", 1'b0, scl_oe_n)
    wr(OFS_SHIFT_DATA, 8'ha5);
    wr(OFS_BUS_CONTROL, 8'hc4);
    i_twst_bus_master.byte_x(8'hff, 1'b0, q, a);
    `CHK("byte one", 8'ha5, q)
    wait_flag();
    chk_sts(ST_DATA_ACK);
    wr(OFS_SHIFT_DATA, 8'h3c);
    wr(OFS_BUS_CONTROL, 8'h84);
    i_twst_bus_master.byte_x(8'hff, 1'b0, q, a);
    `CHK("last byte", 8'h3c, q)
    wait_flag();
    chk_sts(ST_LAST_ACK);
    `CHK("no stretch", 1'b1, scl_oe_n)
    wr(OFS_BUS_CONTROL, 8'he4);
    chk_sts(ST_NO_INFO);
    i_twst_bus_master.byte_x(8'hff, 1'b0, q, a);
    `CHK("idle data", 8'hff, q)
    `CHK("early start", 0, n_start)
    i_twst_bus_master.stop_c();
    i_twst_bus_master.hc(8);
    `CHK("start sent", 1, n_start)
  endtask

  task automatic t_nack_arb();
    i_twst_bus_master.start_c();
    arb <= 1'b1;
    @(posedge i_clk);
    arb <= 1'b0;
    i_twst_bus_master.byte_x(8'h53, 1'b1, q, a);
    wait_flag();
    chk_sts(ST_LOST_READ);
    wr(OFS_SHIFT_DATA, 8'h5a);
    wr(OFS_BUS_CONTROL, 8'h84);
    i_twst_bus_master.byte_x(8'hff, 1'b1, q, a);
    `CHK("nack byte", 8'h5a, q)
    wait_flag();
    chk_sts(ST_DATA_NACK);
    wr(OFS_BUS_CONTROL, 8'h84);
    i_twst_bus_master.stop_c();
    i_twst_bus_master.start_c();
    i_twst_bus_master.byte_x(8'h53, 1'b1, q, a);
    `CHK("off ack", 1'b1, a)
    i_twst_bus_master.stop_c();
  endtask

  task automatic t_ignore();
    wr(OFS_BUS_CONTROL, 8'h44);
    i_twst_bus_master.start_c();
    i_twst_bus_master.byte_x(8'h23, 1'b1, q, a);
    `CHK("other ack", 1'b1, a)
    i_twst_bus_master.start_c();
    i_twst_bus_master.byte_x(8'h52, 1'b1, q, a);
    `CHK("write seen", 1, n_rx)
    i_twst_bus_master.start_c();
    i_twst_bus_master.byte_x(BROADCAST_ADDRESS, 1'b1, q, a);
    `CHK("call seen", 2, n_rx)
    wr(OFS_OWN_ADDRESS, 8'h52);
    i_twst_bus_master.start_c();
    i_twst_bus_master.byte_x(BROADCAST_ADDRESS, 1'b1, q, a);
    `CHK("call off", 2, n_rx)
    i_twst_bus_master.stop_c();
  endtask

  task automatic t_bus_error();
    i_twst_bus_master.start_c();
    repeat (3) i_twst_bus_master.bit_x(1'b1, a);
    i_twst_bus_master.stop_c();
    wait_flag();
    chk_sts(ST_BUS_ERROR);
    wr(OFS_BUS_CONTROL, 8'hc4);
    chk_sts(ST_NO_INFO);
    wr(OFS_BUS_CONTROL, 8'hd4);
    chk_sts(ST_NO_INFO);
    wb_go(OFS_BUS_CONTROL, 1'b0, 8'h00, q);
    `CHK("ctrl after", 8'h44, q)
    `CHK("released", 2'b11, {scl_oe_n, sda_oe_n})
  endtask

  initial
  begin
    i_arst_n = 1'b0;
    {cyc, stb, we, arb} = 4'h0;
    adr = 8'h00;
    dat = 32'h0;
    {failures, n_checks, n_rx, n_start, n_cyc} = '0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    i_twst_bus_master.hc(4);
    t_reset();
    t_read_ack();
    t_nack_arb();
    t_ignore();
    t_bus_error();
    final_report();
  end
endmodule // twst_tb_top

`default_nettype wire
